// ### rtl/pfs_pin_mux.sv
// Contract
// - pc4 goes to lcd common three on code 11, else gpio with ctimer1 clock
// - pc6 becomes uart transmit on code 01, else gpio with ptimer2 clock
// - pc5 becomes uart receive on code 01, else gpio with ptimer3 clock
// - pd1 goes to lcd common one on code 11, else gpio with ptimer0 capture
// - pd0 goes to lcd common zero on code 11, else gpio with ctimer0 clock
// - unimplemented register bits ignore writes and read zero
// - remap bit 3 picks ptimer2 capture from pa7 or pc3
// - remap bit 2 picks ptimer3 clock from pb2 or pc5
// - remap bit 1 picks ptimer2 clock from pa5 or pc6
// - remap bit 0 picks ctimer1 clock from pb3 or pc4
// - remap bit 7 picks ptimer3 capture from pb1 or pd2
// - remap bit 6 picks ptimer0 capture from pa0 or pd1
// - remap bit 5 picks ptimer1 clock from pb4 or pd3
// - remap bit 4 picks ctimer0 clock from pa2 or pd0
// - first drive register holds four two-bit levels for port a and b groups
// - second drive register holds levels for pc6-4, pc3-0 and pd3-0
// - reset sets all port data and direction bits to one
// - new output drives high while data latch keeps reset value
// - single bit set or clear reads whole port, modifies, writes byte back
// - in sleep, falling edge on enabled port a pin wakes the device
// - each port a pin has its own wake enable bit
// - direction one is input, zero output; output reads return the latch
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] padIn,
  output logic      [31:0] padOut,
  output logic      [31:0] padOe,
  input  wire logic        lcdCom0,
  input  wire logic        lcdCom1,
  input  wire logic        lcdCom3,
  input  wire logic        uartTx,
  output logic             uartRx,
  output logic             ctimer0Clk,
  output logic             ctimer1Clk,
  output logic             ptimer1Clk,
  output logic             ptimer2Clk,
  output logic             ptimer3Clk,
  output logic             ptimer0Cap,
  output logic             ptimer2Cap,
  output logic             ptimer3Cap,
  output logic      [13:0] driveLevel,
  input  wire logic        sleepMode,
  output logic             wakeUp
);
  logic [3:0][7:0] dataQ;
  logic [3:0][7:0] dirQ;
  logic [3:0][7:0] portRd;
  logic [7:0]      wakeEnQ;
  logic [7:0]      pcSelQ;
  logic [7:0]      pdSelQ;
  logic [7:0]      remapQ;
  logic [7:0]      drv1Q;
  logic [7:0]      drv2Q;
  logic [7:0]      prevAQ;
  logic            wakeQ;
  logic [31:0]     pinS;
  logic            acc;
  logic            wr;
  logic            portHit;
  logic            hit;
  logic [1:0]      portIdx;
  logic [1:0]      opPort;
  logic [2:0]      opBit;
  logic [7:0]      opCur;
  logic [7:0]      opNew;
  logic [7:0]      fallA;
  logic            pc4Gpio;
  logic            pc5Gpio;
  logic            pc6Gpio;
  logic            pd0Gpio;
  logic            pd1Gpio;

  pfs_sync2 u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (padIn),
    .q     (pinS)
  );

  // apb decode
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign pready  = 1'b1;
  assign portHit = (paddr <= pfs_pkg::PORT_LAST) && (paddr[1:0] == 2'h0);
  assign portIdx = paddr[4:3];

  // port read value: pin for inputs, latch for outputs
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      assign portRd[gp] = (dirQ[gp] & pinS[gp*8 +: 8]) | (~dirQ[gp] & dataQ[gp]);
    end
  endgenerate

  // bit operation: read whole byte, modify one bit, write back
  assign opPort = pwdata[pfs_pkg::OP_PORT_LSB +: 2];
  assign opBit  = pwdata[pfs_pkg::OP_BIT_LSB +: 3];
  assign opCur  = pwdata[pfs_pkg::OP_DIR_BIT] ? dirQ[opPort] : portRd[opPort];

  always_comb begin
    opNew        = opCur;
    opNew[opBit] = pwdata[pfs_pkg::OP_VAL_BIT];
  end

  // read mux and unmapped detection
  always_comb begin
    hit    = 1'b1;
    prdata = 32'h0;
    if (portHit) begin
      prdata[7:0] = paddr[2] ? dirQ[portIdx] : portRd[portIdx];
    end else if (paddr == pfs_pkg::WAKE_EN) begin
      prdata[7:0] = wakeEnQ;
    end else if (paddr == pfs_pkg::PC_SEL) begin
      prdata[7:0] = pcSelQ;
    end else if (paddr == pfs_pkg::PD_SEL) begin
      prdata[7:0] = pdSelQ;
    end else if (paddr == pfs_pkg::REMAP) begin
      prdata[7:0] = remapQ;
    end else if (paddr == pfs_pkg::DRIVE_FIRST) begin
      prdata[7:0] = drv1Q;
    end else if (paddr == pfs_pkg::DRIVE_SEC) begin
      prdata[7:0] = drv2Q;
    end else if (paddr == pfs_pkg::BIT_OP) begin
      prdata = 32'h0;
    end else begin
      hit = 1'b0;
    end
  end

  assign pslverr = acc && !hit;

  // port data and direction latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataQ <= {4{pfs_pkg::PORT_RST}};
      dirQ  <= {4{pfs_pkg::PORT_RST}};
    end else if (wr && portHit) begin
      if (paddr[2]) begin
        dirQ[portIdx] <= pwdata[7:0];
      end else begin
        dataQ[portIdx] <= pwdata[7:0];
      end
    end else if (wr && paddr == pfs_pkg::BIT_OP) begin
      if (pwdata[pfs_pkg::OP_DIR_BIT]) begin
        dirQ[opPort] <= opNew;
      end else begin
        dataQ[opPort] <= opNew;
      end
    end
  end

  // function select, remap and wake enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeEnQ <= pfs_pkg::SEL_RST;
      pcSelQ  <= pfs_pkg::SEL_RST;
      pdSelQ  <= pfs_pkg::SEL_RST;
      remapQ  <= pfs_pkg::SEL_RST;
    end else if (wr) begin
      if (paddr == pfs_pkg::WAKE_EN) begin
        wakeEnQ <= pwdata[7:0];
      end else if (paddr == pfs_pkg::PC_SEL) begin
        pcSelQ <= pwdata[7:0] & pfs_pkg::PC_SEL_MASK;
      end else if (paddr == pfs_pkg::PD_SEL) begin
        pdSelQ <= pwdata[7:0] & pfs_pkg::PD_SEL_MASK;
      end else if (paddr == pfs_pkg::REMAP) begin
        remapQ <= pwdata[7:0];
      end
    end
  end

  // source current level registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv1Q <= pfs_pkg::DRV1_RST;
      drv2Q <= pfs_pkg::DRV2_RST;
    end else if (wr && paddr == pfs_pkg::DRIVE_FIRST) begin
      drv1Q <= pwdata[7:0];
    end else if (wr && paddr == pfs_pkg::DRIVE_SEC) begin
      drv2Q <= pwdata[7:0] & pfs_pkg::DRV2_MASK;
    end
  end

  assign driveLevel = {drv2Q[5:0], drv1Q};

  // pin function selection
  assign pc4Gpio = pcSelQ[pfs_pkg::PC4_LSB +: 2] != pfs_pkg::SEL_LCD;
  assign pc5Gpio = pcSelQ[pfs_pkg::PC5_LSB +: 2] != pfs_pkg::SEL_UART;
  assign pc6Gpio = pcSelQ[pfs_pkg::PC6_LSB +: 2] != pfs_pkg::SEL_UART;
  assign pd0Gpio = pdSelQ[pfs_pkg::PD0_LSB +: 2] != pfs_pkg::SEL_LCD;
  assign pd1Gpio = pdSelQ[pfs_pkg::PD1_LSB +: 2] != pfs_pkg::SEL_LCD;

  always_comb begin
    padOut = dataQ;
    padOe  = ~dirQ;
    if (!pc4Gpio) begin
      padOut[pfs_pkg::PC4] = lcdCom3;
      padOe[pfs_pkg::PC4]  = 1'b1;
    end
    if (!pc5Gpio) begin
      padOut[pfs_pkg::PC5] = 1'b0;
      padOe[pfs_pkg::PC5]  = 1'b0;
    end
    if (!pc6Gpio) begin
      padOut[pfs_pkg::PC6] = uartTx;
      padOe[pfs_pkg::PC6]  = 1'b1;
    end
    if (!pd0Gpio) begin
      padOut[pfs_pkg::PD0] = lcdCom0;
      padOe[pfs_pkg::PD0]  = 1'b1;
    end
    if (!pd1Gpio) begin
      padOut[pfs_pkg::PD1] = lcdCom1;
      padOe[pfs_pkg::PD1]  = 1'b1;
    end
  end

  assign uartRx = pc5Gpio ? 1'b1 : pinS[pfs_pkg::PC5];

  // timer input remapping; unselected pin has no path
  assign ctimer1Clk = remapQ[pfs_pkg::CT1_CK_BIT] ? (pc4Gpio & pinS[pfs_pkg::PC4])
                                                  : pinS[pfs_pkg::PB3];
  assign ptimer2Clk = remapQ[pfs_pkg::PT2_CK_BIT] ? (pc6Gpio & pinS[pfs_pkg::PC6])
                                                  : pinS[pfs_pkg::PA5];
  assign ptimer3Clk = remapQ[pfs_pkg::PT3_CK_BIT] ? (pc5Gpio & pinS[pfs_pkg::PC5])
                                                  : pinS[pfs_pkg::PB2];
  assign ptimer2Cap = remapQ[pfs_pkg::PT2_CP_BIT] ? pinS[pfs_pkg::PC3]
                                                  : pinS[pfs_pkg::PA7];
  assign ctimer0Clk = remapQ[pfs_pkg::CT0_CK_BIT] ? (pd0Gpio & pinS[pfs_pkg::PD0])
                                                  : pinS[pfs_pkg::PA2];
  assign ptimer1Clk = remapQ[pfs_pkg::PT1_CK_BIT] ? pinS[pfs_pkg::PD3]
                                                  : pinS[pfs_pkg::PB4];
  assign ptimer0Cap = remapQ[pfs_pkg::PT0_CP_BIT] ? (pd1Gpio & pinS[pfs_pkg::PD1])
                                                  : pinS[pfs_pkg::PA0];
  assign ptimer3Cap = remapQ[pfs_pkg::PT3_CP_BIT] ? pinS[pfs_pkg::PD2]
                                                  : pinS[pfs_pkg::PB1];

  // port a falling edge wake
  assign fallA = prevAQ & ~pinS[7:0] & wakeEnQ;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevAQ <= pfs_pkg::PORT_RST;
      wakeQ  <= 1'b0;
    end else begin
      prevAQ <= pinS[7:0];
      wakeQ  <= sleepMode && (|fallA);
    end
  end

  assign wakeUp = wakeQ;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  pc4_lcd_a: assert property (
    pcSelQ[1:0] == 2'h3 |-> padOe[20] && padOut[20] == lcdCom3 && (!remapQ[0] || !ctimer1Clk))
    else $error("pc4 not routed to lcd common three");

  pc6_tx_a: assert property (
    pcSelQ[5:4] == 2'h1 |-> padOe[22] && padOut[22] == uartTx)
    else $error("pc6 not routed to uart transmit");

  pc5_rx_a: assert property (
    uartRx == ((pcSelQ[3:2] == 2'h1) ? pinS[21] : 1'b1))
    else $error("uart receive source wrong");

  pd1_lcd_a: assert property (
    pdSelQ[3:2] == 2'h3 |-> padOe[25] && padOut[25] == lcdCom1)
    else $error("pd1 not routed to lcd common one");

  pd0_lcd_a: assert property (
    pdSelQ[1:0] == 2'h3 |-> padOe[24] && padOut[24] == lcdCom0)
    else $error("pd0 not routed to lcd common zero");

  sel_reserved_a: assert property (
    wr && paddr == 8'h24 && pwdata[7:0] == 8'hff |=> pcSelQ == 8'h3f)
    else $error("reserved select bits stored");

  cap2_remap_a: assert property (
    ptimer2Cap == (remapQ[3] ? pinS[19] : pinS[7]))
    else $error("ptimer2 capture source wrong");

  ct1_remap_a: assert property (
    remapQ[0] && pcSelQ[1:0] != 2'h3 && $stable(pinS[20]) |-> ctimer1Clk == pinS[20])
    else $error("ctimer1 clock source wrong");

  rmw_byte_a: assert property (
    wr && paddr == 8'h38 && !pwdata[3] |=>
      dataQ[$past(pwdata[5:4])] == $past(opNew))
    else $error("bit operation write back wrong");

  out_latch_a: assert property (
    acc && !pwrite && paddr == pfs_pkg::PORT_DATA_A |->
      (prdata[7:0] & ~dirQ[0]) == (dataQ[0] & ~dirQ[0]))
    else $error("output read not from latch");

  in_read_a: assert property (
    acc && !pwrite && paddr == pfs_pkg::PORT_DATA_A |->
      (prdata[7:0] & dirQ[0]) == (pinS[7:0] & dirQ[0]))
    else $error("input read not from pin");

  wake_edge_a: assert property (
    sleepMode && (|(prevAQ & ~pinS[7:0] & wakeEnQ)) |=>
      wakeUp ##1 (!wakeUp || $past(sleepMode && (|fallA))))
    else $error("wake pulse missing");

  no_wake_a: assert property (
    !sleepMode || wakeEnQ == 8'h00 |=> !wakeUp)
    else $error("wake without enable or sleep");

  port_reset_a: assert property (
    $rose(rst_n) |-> dataQ == {4{pfs_pkg::PORT_RST}} && dirQ == {4{pfs_pkg::PORT_RST}})
    else $error("port latches not high after reset");

  drive_reset_a: assert property (
    $rose(rst_n) |-> drv1Q == pfs_pkg::DRV1_RST && drv2Q == pfs_pkg::DRV2_RST)
    else $error("drive levels wrong after reset");

  new_out_high_a: assert property (
    wr && paddr == pfs_pkg::PORT_DIR_A && dataQ[0] == pfs_pkg::PORT_RST |=>
      (padOut[7:0] & padOe[7:0]) == padOe[7:0])
    else $error("new output not driving high");

  upper_zero_a: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("unimplemented read bits not zero");

  rmw_dir_a: assert property (
    wr && paddr == pfs_pkg::BIT_OP && pwdata[pfs_pkg::OP_DIR_BIT] |=>
      dirQ[$past(pwdata[5:4])][$past(pwdata[2:0])] == $past(pwdata[pfs_pkg::OP_VAL_BIT]))
    else $error("bit operation on direction wrong");

  pt3_clk_a: assert property (
    !remapQ[pfs_pkg::PT3_CK_BIT] |-> ptimer3Clk == pinS[pfs_pkg::PB2])
    else $error("ptimer3 clock not from default pin");
endmodule // pfs_pin_mux
`default_nettype wire

// ### inc/pfs_pkg.sv
`default_nettype none
package pfs_pkg;
  // apb byte offsets
  localparam logic [7:0] PORT_DATA_A = 8'h00;
  localparam logic [7:0] PORT_DIR_A  = 8'h04;
  localparam logic [7:0] PORT_LAST   = 8'h1c;
  localparam logic [7:0] WAKE_EN     = 8'h20;
  localparam logic [7:0] PC_SEL      = 8'h24;
  localparam logic [7:0] PD_SEL      = 8'h28;
  localparam logic [7:0] REMAP       = 8'h2c;
  localparam logic [7:0] DRIVE_FIRST = 8'h30;
  localparam logic [7:0] DRIVE_SEC   = 8'h34;
  localparam logic [7:0] BIT_OP      = 8'h38;

  // implemented bits per register
  localparam logic [7:0] PC_SEL_MASK = 8'h3f;
  localparam logic [7:0] PD_SEL_MASK = 8'h0f;
  localparam logic [7:0] DRV2_MASK   = 8'h3f;

  // values after reset
  localparam logic [7:0] PORT_RST    = 8'hff;
  localparam logic [7:0] SEL_RST     = 8'h00;
  localparam logic [7:0] DRV1_RST    = 8'h00;
  localparam logic [7:0] DRV2_RST    = 8'h15;

  // select codes
  localparam logic [1:0] SEL_LCD     = 2'h3;
  localparam logic [1:0] SEL_UART    = 2'h1;

  // field positions: pin select fields
  localparam int PC4_LSB = 0;
  localparam int PC5_LSB = 2;
  localparam int PC6_LSB = 4;
  localparam int PD0_LSB = 0;
  localparam int PD1_LSB = 2;

  // remap bits
  localparam int CT1_CK_BIT = 0;
  localparam int PT2_CK_BIT = 1;
  localparam int PT3_CK_BIT = 2;
  localparam int PT2_CP_BIT = 3;
  localparam int CT0_CK_BIT = 4;
  localparam int PT1_CK_BIT = 5;
  localparam int PT0_CP_BIT = 6;
  localparam int PT3_CP_BIT = 7;

  // bit operation word fields
  localparam int OP_BIT_LSB  = 0;
  localparam int OP_DIR_BIT  = 3;
  localparam int OP_PORT_LSB = 4;
  localparam int OP_VAL_BIT  = 8;

  // pin positions on the pad vector (a 7:0, b 15:8, c 23:16, d 31:24)
  localparam int PA0 = 0;
  localparam int PA2 = 2;
  localparam int PA5 = 5;
  localparam int PA7 = 7;
  localparam int PB1 = 9;
  localparam int PB2 = 10;
  localparam int PB3 = 11;
  localparam int PB4 = 12;
  localparam int PC3 = 19;
  localparam int PC4 = 20;
  localparam int PC5 = 21;
  localparam int PC6 = 22;
  localparam int PD0 = 24;
  localparam int PD1 = 25;
  localparam int PD2 = 26;
  localparam int PD3 = 27;
endpackage
`default_nettype wire

// ### rtl/pfs_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_sync2 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] d,
  output logic      [31:0] q
);
  logic [31:0] meta_q;

  // two-stage pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 32'hffffffff;
      q      <= 32'hffffffff;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // pfs_sync2
`default_nettype wire

// ### verification/pfs_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model (
  input  wire logic [31:0] padOut,
  input  wire logic [31:0] padOe,
  input  wire logic [31:0] extLevel,
  output logic      [31:0] padIn
);
  // driven pins read back their own level, released pins the outside level
  always_comb padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule // pfs_pad_model
`default_nettype wire

// ### verification/test_port_function_select_and_drive.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_function_select_and_drive;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        lcdCom0, lcdCom1, lcdCom3, uartTx, uartRx, sleepMode, wakeUp, e;
  logic [7:0]  paddr;
  logic [13:0] driveLevel;
  logic [31:0] pwdata, prdata, padIn, padOut, padOe, ext, r;
  wire  [7:0]  tmr;
  int          err_count, checked;
  int          defPin [8] = '{pfs_pkg::PB3, pfs_pkg::PA5, pfs_pkg::PB2, pfs_pkg::PA7,
                              pfs_pkg::PA2, pfs_pkg::PB4, pfs_pkg::PA0, pfs_pkg::PB1};
  int          altPin [8] = '{pfs_pkg::PC4, pfs_pkg::PC6, pfs_pkg::PC5, pfs_pkg::PC3,
                              pfs_pkg::PD0, pfs_pkg::PD3, pfs_pkg::PD1, pfs_pkg::PD2};

  pfs_pin_mux u_pfs_pin_mux (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .padIn, .padOut, .padOe, .lcdCom0, .lcdCom1, .lcdCom3, .uartTx, .uartRx,
    .ctimer1Clk(tmr[0]), .ptimer2Clk(tmr[1]), .ptimer3Clk(tmr[2]), .ptimer2Cap(tmr[3]),
    .ctimer0Clk(tmr[4]), .ptimer1Clk(tmr[5]), .ptimer0Cap(tmr[6]), .ptimer3Cap(tmr[7]),
    .driveLevel, .sleepMode, .wakeUp
  );
  pfs_pad_model u_pfs_pad_model (.padOut, .padOe, .extLevel(ext), .padIn);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic t_reset;
    chk(padOe, 32'h0);
    chk(padOut, 32'hffffffff);
    for (int p = 0; p < 4; p++) begin
      rd(8'(8 * p), 32'hff);
      rd(8'(8 * p + 4), 32'hff);
    end
    rd(pfs_pkg::REMAP, 32'h0);
    rd(pfs_pkg::DRIVE_FIRST, 32'h0);
    rd(pfs_pkg::DRIVE_SEC, 32'h15);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    wr(pfs_pkg::PC_SEL, 32'hff);
    rd(pfs_pkg::PC_SEL, 32'h3f);
    wr(pfs_pkg::PD_SEL, 32'hff);
    rd(pfs_pkg::PD_SEL, 32'h0f);
    wr(pfs_pkg::DRIVE_SEC, 32'hff);
    rd(pfs_pkg::DRIVE_SEC, 32'h3f);
    wr(pfs_pkg::DRIVE_SEC, 32'h26);
    wr(pfs_pkg::DRIVE_FIRST, 32'hc9);
    rd(pfs_pkg::DRIVE_FIRST, 32'hc9);
    chk(32'(driveLevel), 32'h26c9);
    wr(8'h3c, 32'hff);
    chk(32'(e), 32'h1);
    rd(8'h3c, 32'h0);
    wr(pfs_pkg::PC_SEL, 32'h0);
    wr(pfs_pkg::PD_SEL, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_remap;
    for (int i = 0; i < 8; i++) begin
      wr(pfs_pkg::REMAP, 32'h0);
      ext[altPin[i]] <= 1'b0;
      cyc(4);
      chk(32'(tmr[i]), 32'h1);
      wr(pfs_pkg::REMAP, 32'h1 << i);
      cyc(4);
      chk(32'(tmr[i]), 32'h0);
      ext[altPin[i]] <= 1'b1;
      ext[defPin[i]] <= 1'b0;
      cyc(4);
      chk(32'(tmr[i]), 32'h1);
      ext[defPin[i]] <= 1'b1;
    end
    wr(pfs_pkg::REMAP, 32'h0);
    $display("t_remap done");
  endtask

  task automatic t_func;
    ext[pfs_pkg::PC5] <= 1'b0;
    wr(pfs_pkg::PC_SEL, 32'h2e);
    wr(pfs_pkg::PD_SEL, 32'h0a);
    cyc(4);
    chk(32'({padOe[25:20], padOut[25:20], uartRx}), 32'h7f);
    wr(pfs_pkg::PC_SEL, 32'h17);
    wr(pfs_pkg::PD_SEL, 32'h0f);
    wr(pfs_pkg::REMAP, 32'h01);
    for (int v = 0; v < 2; v++) begin
      lcdCom3 <= v[0];
      lcdCom0 <= v[0];
      lcdCom1 <= ~v[0];
      uartTx <= v[0];
      ext[pfs_pkg::PC5] <= v[0];
      cyc(4);
      chk(32'({padOe[22], padOe[20], padOut[22], padOut[20], uartRx}), 32'({2'b11, {3{v[0]}}}));
      chk(32'({padOe[25:24], padOut[25:24]}), 32'({2'b11, ~v[0], v[0]}));
      chk(32'(tmr[0]), 32'h0);
    end
    wr(pfs_pkg::REMAP, 32'h0);
    wr(pfs_pkg::PC_SEL, 32'h0);
    wr(pfs_pkg::PD_SEL, 32'h0);
    $display("t_func done");
  endtask

  task automatic t_bitop;
    ext[7:0] <= 8'h0a;
    wr(pfs_pkg::PORT_DIR_A, 32'h0f);
    cyc(1);
    chk(32'({padOe[7:0], padOut[7:4]}), 32'hf0f);
    rd(pfs_pkg::PORT_DATA_A, 32'hfa);
    wr(pfs_pkg::BIT_OP, 32'h007);
    wr(pfs_pkg::PORT_DIR_A, 32'h00);
    cyc(1);
    chk(32'({padOe[7:0], padOut[7:0]}), 32'hff7a);
    wr(pfs_pkg::BIT_OP, 32'h018);
    rd(pfs_pkg::PORT_DIR_A + 8'h08, 32'hfe);
    wr(pfs_pkg::PORT_DIR_A, 32'hff);
    wr(pfs_pkg::PORT_DIR_A + 8'h08, 32'hff);
    ext[7:0] <= 8'hff;
    $display("t_bitop done");
  endtask

  task automatic fall(input int b, input int exp);
    int n;
    n = 0;
    ext[b] <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      n += int'(wakeUp === 1'b1);
    end
    @(posedge clk);
    ext[b] <= 1'b1;
    cyc(4);
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_wake;
    wr(pfs_pkg::WAKE_EN, 32'h08);
    rd(pfs_pkg::WAKE_EN, 32'h08);
    sleepMode <= 1'b1;
    fall(pfs_pkg::PA0 + 3, 1);
    fall(pfs_pkg::PA5, 0);
    sleepMode <= 1'b0;
    fall(pfs_pkg::PA0 + 3, 0);
    wr(pfs_pkg::WAKE_EN, 32'h28);
    sleepMode <= 1'b1;
    fall(pfs_pkg::PA5, 1);
    $display("t_wake done");
  endtask

  task automatic t_rerst;
    wr(pfs_pkg::PORT_DIR_A, 32'h00);
    wr(pfs_pkg::DRIVE_SEC, 32'h3f);
    wr(pfs_pkg::REMAP, 32'hff);
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    t_reset;
    $display("t_rerst done");
  endtask

  task automatic close_out;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_n, psel, penable, pwrite, lcdCom0, lcdCom1, lcdCom3, uartTx, sleepMode} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext = 32'hffffffff;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_remap;
    t_func;
    t_bitop;
    t_wake;
    t_rerst;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule // test_port_function_select_and_drive
`default_nettype wire
